// *** rtl/vavr_pkg.sv ***
// vavr_pkg: shared constants and types of the actuator register bank
// assumes one 100 MHz clock and 16-bit holding registers by register number
package vavr_pkg;

	// ----------------------------------------------------------------
	// register numbers
	// ----------------------------------------------------------------
	localparam logic [15:0] REG_SETPOINT   = 16'h0001; // setpoint, held outside
	localparam logic [15:0] REG_OVERRIDE   = 16'h0002; // override, held outside
	localparam logic [15:0] REG_COMMAND    = 16'h0003; // command, decoded here
	localparam logic [15:0] REG_ABS_FLOW   = 16'h0008;
	localparam logic [15:0] REG_SENSOR_VAL = 16'h0009;
	localparam logic [15:0] REG_SERIAL_1   = 16'h0065;
	localparam logic [15:0] REG_SERIAL_2   = 16'h0066;
	localparam logic [15:0] REG_SERIAL_4   = 16'h0067;
	localparam logic [15:0] REG_FIRMWARE   = 16'h0068;
	localparam logic [15:0] REG_STATUS     = 16'h0069;
	localparam logic [15:0] REG_MIN_LIMIT  = 16'h006a;
	localparam logic [15:0] REG_MAX_LIMIT  = 16'h006b;
	localparam logic [15:0] REG_SENS_KIND  = 16'h006c;
	localparam logic [15:0] REG_FAIL_POS   = 16'h006d;
	localparam logic [15:0] REG_RESERVED   = 16'h006e;
	localparam logic [15:0] REG_NOM_FLOW   = 16'h006f;

	// ----------------------------------------------------------------
	// codes, fields and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] CMD_CLEAR_FAULTS = 16'h0004;
	localparam logic [15:0] TYPE_FLOW_CTRL   = 16'h0002;
	localparam logic [15:0] NOT_AVAILABLE    = 16'hffff;
	localparam logic [15:0] LIM_ZERO         = 16'h0000;
	localparam logic [15:0] LIM_MAX_LOW      = 16'h07d0; // 2000 = 20 %
	localparam logic [15:0] LIM_FULL         = 16'h2710; // 10000 = 100 %
	localparam logic [7:0]  MALF_USED_MASK   = 8'hf7;    // bit 3 unused
	localparam logic [7:0]  MALF_KEEP_MASK   = 8'h11;    // bits 0 and 4 stay
	localparam int          SVC_ACTIVITY_BIT = 0;        // status bit 8
	localparam int          SVC_GEAR_BIT     = 1;        // status bit 9
	localparam int          SVC_BUSMON_BIT   = 2;        // status bit 10

	// sensor kind codes
	typedef enum logic [2:0] {
		SENS_NONE    = 3'b000,
		SENS_MV      = 3'b001,
		SENS_CONTACT = 3'b100
	} vavr_sens_t;

	// bus fail position codes
	typedef enum logic [1:0] {
		FAIL_KEEP  = 2'b00,
		FAIL_CLOSE = 2'b01,
		FAIL_OPEN  = 2'b10,
		FAIL_MID   = 2'b11
	} vavr_fail_t;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_NS = 1000000; // 1 ms base tick
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int WDOG_TIMEOUT_S = 120;
	localparam int WDOG_TICKS     = WDOG_TIMEOUT_S * 1000;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        wr;    // write strobe, one cycle
		logic        rd;    // read strobe, one cycle
		logic [15:0] addr;  // register number
		logic [15:0] wdata; // write data
	} vavr_req_t;

	typedef struct packed {
		logic [15:0] act_type;  // actuator type code
		logic [15:0] abs_flow;  // measured absolute flow
		logic [15:0] nom_flow;  // nominal flow set by box maker
		logic [15:0] sensor_mv; // digitised sensor input in mV
		logic        contact;   // local input closed
		logic [7:0]  malf_evt;  // malfunction event pulses
		logic        activity;  // test run or adaptation running
		logic        gear_off;  // gear disengaged
	} vavr_plant_t;

	typedef struct packed {
		logic [15:0] min_lim;
		logic [15:0] max_lim;
		vavr_sens_t  sens_kind;
		vavr_fail_t  fail_mode;
		logic [7:0]  malf;
		logic [2:0]  svc;
		logic [31:0] tick_cnt;
		logic [31:0] wd_cnt;
		logic        wd_fired;
		logic        local_ovr;
		logic [15:0] rdata;
		logic        rvalid;
	} vavr_state_t;

	localparam vavr_state_t STATE_RST = '{
		min_lim: LIM_ZERO, max_lim: LIM_FULL, sens_kind: SENS_NONE,
		fail_mode: FAIL_KEEP, malf: 8'h00, svc: 3'b000, tick_cnt: 32'h0000_0000,
		wd_cnt: 32'h0000_0000, wd_fired: 1'b0, local_ovr: 1'b0,
		rdata: 16'h0000, rvalid: 1'b0};

endpackage

// *** rtl/vavr_regs.sv ***
// vavr_regs: upper holding-register bank of the damper actuator
// assumes a protocol engine that decodes frames into one-cycle strobes
`timescale 1ns/100ps

// Function
// - absolute flow reads 65535 unless type 2
// - sensor value follows chosen sensor type
// - status: faults low byte, service high byte
// - fault bits 0,1,2,4..7; bit 3 unused
// - service bits 8,9,10; 11..15 unused
// - command 4 clears resettable fault flags
// - fault bits 0 and 4 never cleared
// - minimum limit accepts 0 to 10000
// - maximum limit accepts 2000 to 10000
// - sensor type codes 0, 1, 4 only
// - no sensor: local input forces override
// - default: no supervision, keep setpoint
// - 120 s without refresh: go fail position
// - timeout sets bus monitoring status flag
// - fail codes: keep, close, open, mid
// - reserved register has no function
// - nominal flow 65535 unless type 2
// - only type 2 gives flow values
module vavr_regs #(
	parameter int          TICK_CYC  = vavr_pkg::TICK_CYCLES, // cycles per 1 ms tick
	parameter int          WD_TICKS  = vavr_pkg::WDOG_TICKS,  // ticks to timeout
	parameter logic [15:0] SERIAL_W1 = 16'h1111,              // arbitrary value
	parameter logic [15:0] SERIAL_W2 = 16'h2222,              // arbitrary value
	parameter logic [15:0] SERIAL_W4 = 16'h4444,              // arbitrary value
	parameter logic [15:0] FW_VER    = 16'h0101               // arbitrary value
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	// register access
	input  wire vavr_pkg::vavr_req_t   req,
	output logic [15:0]                rdata,
	output logic                       rvalid,
	// plant side
	input  wire vavr_pkg::vavr_plant_t plant,
	// control outputs
	output logic [15:0]                min_limit,
	output logic [15:0]                max_limit,
	output vavr_pkg::vavr_sens_t       sensor_kind,
	output vavr_pkg::vavr_fail_t       fail_mode,
	output logic                       bus_fail_active,
	output logic                       local_override,
	output logic [15:0]                status_word
);
	import vavr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	vavr_state_t st_reg;  // all state of the bank
	vavr_state_t st_next; // its next value

	// limit check shared by both limit registers
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	// flow values exist only for flow controller types
	function automatic logic [15:0] flow_or_na(input logic [15:0] t, input logic [15:0] v);
		flow_or_na = (t == TYPE_FLOW_CTRL) ? v : NOT_AVAILABLE;
	endfunction

	// status word as seen by the master
	function automatic logic [15:0] status_of(input vavr_state_t s);
		status_of = {5'b00000, s.svc, s.malf & MALF_USED_MASK};
	endfunction

	// sensor value as read, per chosen kind
	function automatic logic [15:0] sensor_of(input vavr_sens_t k, input vavr_plant_t p);
		unique case (k)
			SENS_MV:      sensor_of = p.sensor_mv;
			SENS_CONTACT: sensor_of = {15'h0000, p.contact};
			default:      sensor_of = 16'h0000;                  // no sensor
		endcase
	endfunction

	// ----------------------------------------------------------------
	// decoded strobes
	// ----------------------------------------------------------------
	logic wr_refresh; // setpoint or override renewed
	logic wr_clear;   // command 4 written
	logic tick;       // 1 ms enable pulse

	assign wr_refresh = req.wr && (req.addr == REG_SETPOINT || req.addr == REG_OVERRIDE);
	assign wr_clear   = req.wr && req.addr == REG_COMMAND && req.wdata == CMD_CLEAR_FAULTS;
	assign tick       = st_reg.tick_cnt == 32'(TICK_CYC - 1);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;

		// register writes; out-of-range values are ignored
		if (req.wr) begin
			unique case (req.addr)
				REG_MIN_LIMIT: begin
					if (in_range(req.wdata, LIM_ZERO, LIM_FULL)) begin
						st_next.min_lim = req.wdata;
					end
				end
				REG_MAX_LIMIT: begin
					if (in_range(req.wdata, LIM_MAX_LOW, LIM_FULL)) begin
						st_next.max_lim = req.wdata;
					end
				end
				REG_SENS_KIND: begin
					// only defined codes accepted; takes effect at the next edge
					if (req.wdata == 16'({SENS_NONE}) || req.wdata == 16'({SENS_MV})
							|| req.wdata == 16'({SENS_CONTACT})) begin
						st_next.sens_kind = vavr_sens_t'(req.wdata[2:0]);
					end
				end
				REG_FAIL_POS: begin
					if (req.wdata[15:2] == 14'h0000) begin
						st_next.fail_mode = vavr_fail_t'(req.wdata[1:0]);
					end
				end
				default: begin
					// reserved slot and read-only numbers ignore writes
				end
			endcase
		end

		// malfunction flags: clear first, then events win
		if (wr_clear) begin
			st_next.malf = st_reg.malf & MALF_KEEP_MASK;
		end
		st_next.malf = st_next.malf | (plant.malf_evt & MALF_USED_MASK);

		// service levels follow the plant
		st_next.svc[SVC_ACTIVITY_BIT] = plant.activity;
		st_next.svc[SVC_GEAR_BIT]     = plant.gear_off;

		// bus supervision watchdog
		if (st_next.fail_mode == FAIL_KEEP) begin
			// unsupervised: hold last setpoint
			st_next.tick_cnt = 32'h0000_0000;
			st_next.wd_cnt   = 32'h0000_0000;
			st_next.wd_fired = 1'b0;
		end else if (wr_refresh) begin
			// refresh restarts timing and ends fail state
			st_next.tick_cnt = 32'h0000_0000;
			st_next.wd_cnt   = 32'h0000_0000;
			st_next.wd_fired = 1'b0;
		end else if (!st_reg.wd_fired) begin
			// divider and tick count toward the timeout
			st_next.tick_cnt = tick ? 32'h0000_0000 : st_reg.tick_cnt + 32'h0000_0001;
			if (tick) begin
				st_next.wd_cnt = st_reg.wd_cnt + 32'h0000_0001;
				if (st_reg.wd_cnt == 32'(WD_TICKS - 1)) begin
					st_next.wd_fired = 1'b1;
				end
			end
		end
		st_next.svc[SVC_BUSMON_BIT] = st_next.wd_fired;

		// local input acts as override when no sensor chosen
		st_next.local_ovr = (st_reg.sens_kind == SENS_NONE) && plant.contact;

		// read answer one cycle after the strobe
		if (req.rd) begin
			st_next.rvalid = 1'b1;
			unique case (req.addr)
				REG_ABS_FLOW:   st_next.rdata = flow_or_na(plant.act_type, plant.abs_flow);
				REG_SENSOR_VAL: st_next.rdata = sensor_of(st_reg.sens_kind, plant);
				REG_SERIAL_1:   st_next.rdata = SERIAL_W1;
				REG_SERIAL_2:   st_next.rdata = SERIAL_W2;
				REG_SERIAL_4:   st_next.rdata = SERIAL_W4;
				REG_FIRMWARE:   st_next.rdata = FW_VER;
				REG_STATUS:     st_next.rdata = status_of(st_reg);
				REG_MIN_LIMIT:  st_next.rdata = st_reg.min_lim;
				REG_MAX_LIMIT:  st_next.rdata = st_reg.max_lim;
				REG_SENS_KIND:  st_next.rdata = 16'({st_reg.sens_kind});
				REG_FAIL_POS:   st_next.rdata = 16'({st_reg.fail_mode});
				REG_NOM_FLOW:   st_next.rdata = flow_or_na(plant.act_type, plant.nom_flow);
				default:        st_next.rdata = 16'h0000; // reserved and unmapped
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_reg <= STATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign rdata           = st_reg.rdata;
	assign rvalid          = st_reg.rvalid;
	assign min_limit       = st_reg.min_lim;
	assign max_limit       = st_reg.max_lim;
	assign sensor_kind     = st_reg.sens_kind;
	assign fail_mode       = st_reg.fail_mode;
	assign bus_fail_active = st_reg.wd_fired;
	assign local_override  = st_reg.local_ovr;
	assign status_word     = status_of(st_reg);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_ABS_FLOW_NA: assert property (
		req.rd && req.addr == REG_ABS_FLOW && plant.act_type != TYPE_FLOW_CTRL
		|=> rvalid && rdata == 16'hffff)
		else $error("absolute flow not 65535 for non flow type");

	AST_NOM_FLOW_NA: assert property (
		req.rd && req.addr == REG_NOM_FLOW && plant.act_type != TYPE_FLOW_CTRL
		|=> rvalid && rdata == 16'hffff)
		else $error("nominal flow not 65535 for non flow type");

	AST_FLOW_PASS: assert property (
		req.rd && req.addr == REG_ABS_FLOW && plant.act_type == TYPE_FLOW_CTRL
		|=> rdata == $past(plant.abs_flow))
		else $error("flow value not passed for flow type");

	AST_SENSOR_MV: assert property (
		req.rd && req.addr == REG_SENSOR_VAL && sensor_kind == SENS_MV
		|=> rdata == $past(plant.sensor_mv))
		else $error("sensor value not mV reading");

	AST_BIT3_ZERO: assert property (
		status_word[3] == 1'b0 && status_word[15:11] == 5'b00000)
		else $error("unused status bit set");

	AST_CLEAR: assert property (
		wr_clear && plant.malf_evt == 8'h00 |=> (status_word[7:0] & 8'hee) == 8'h00)
		else $error("resettable fault not cleared");

	AST_KEEP: assert property (
		wr_clear && status_word[0] && status_word[4] |=> status_word[0] && status_word[4])
		else $error("non resettable fault cleared");

	AST_EVT_WINS: assert property (
		wr_clear && plant.malf_evt[1] |=> status_word[1])
		else $error("fault event lost against clear");

	AST_MIN_RANGE: assert property (
		min_limit <= 16'h2710)
		else $error("minimum limit above 10000");

	AST_MAX_RANGE: assert property (
		max_limit >= 16'h07d0 && max_limit <= 16'h2710)
		else $error("maximum limit out of range");

	AST_KIND_CODE: assert property (
		sensor_kind == SENS_NONE || sensor_kind == SENS_MV || sensor_kind == SENS_CONTACT)
		else $error("illegal sensor kind");

	AST_OVERRIDE: assert property (
		sensor_kind == SENS_NONE && plant.contact && !(req.wr && req.addr == REG_SENS_KIND)
		|=> local_override)
		else $error("local override missing");

	AST_NO_SUPERVISION: assert property (
		fail_mode == FAIL_KEEP |-> !bus_fail_active)
		else $error("fail state without supervision");

	AST_FLAG_TRACKS: assert property (
		status_word[10] == bus_fail_active)
		else $error("bus monitoring flag mismatch");

	AST_REFRESH: assert property (
		wr_refresh |=> !bus_fail_active && st_reg.wd_cnt == 32'h0000_0000)
		else $error("refresh did not restart supervision");

	AST_FIRE: assert property (
		fail_mode != FAIL_KEEP && tick && st_reg.wd_cnt == 32'(WD_TICKS - 1)
		&& !wr_refresh && !(req.wr && req.addr == REG_FAIL_POS) |=> bus_fail_active)
		else $error("timeout did not fire");

	// a cycle without a read strobe leaves no answer marker
	AST_RVALID_PULSE: assert property (
		!req.rd |=> !rvalid)
		else $error("read marker without read strobe");

	// contact kind reads the local input in bit 0
	AST_SENSOR_CONTACT: assert property (
		req.rd && req.addr == REG_SENSOR_VAL && sensor_kind == SENS_CONTACT
		|=> rvalid && rdata == {15'h0000, $past(plant.contact)})
		else $error("sensor value not contact level");

	// no sensor chosen reads as zero
	AST_SENSOR_NONE: assert property (
		req.rd && req.addr == REG_SENSOR_VAL && sensor_kind == SENS_NONE
		|=> rvalid && rdata == 16'h0000)
		else $error("sensor value not zero without sensor");

	// reserved slot answers zero
	AST_RSVD_READ: assert property (
		req.rd && req.addr == REG_RESERVED |=> rvalid && rdata == 16'h0000)
		else $error("reserved register not zero");

	// service levels reach bits 8 and 9 one cycle later
	AST_SVC_LEVELS: assert property (
		1'b1 |=> status_word[9:8] == {$past(plant.gear_off), $past(plant.activity)})
		else $error("service bits do not follow plant");

	// fault flags only drop through the clear command
	AST_MALF_STICKY: assert property (
		!wr_clear |=> (status_word[7:0] & $past(status_word[7:0])) == $past(status_word[7:0]))
		else $error("fault flag dropped without clear");

	// accepted minimum limit lands at the next edge
	AST_MIN_WRITE: assert property (
		req.wr && req.addr == REG_MIN_LIMIT && req.wdata <= LIM_FULL
		|=> min_limit == $past(req.wdata))
		else $error("valid minimum limit not taken");

	// accepted maximum limit lands at the next edge
	AST_MAX_WRITE: assert property (
		req.wr && req.addr == REG_MAX_LIMIT && req.wdata >= LIM_MAX_LOW && req.wdata <= LIM_FULL
		|=> max_limit == $past(req.wdata))
		else $error("valid maximum limit not taken");

	// ----------------------------------------------------------------
	// cover points
	// ----------------------------------------------------------------
	// main scenarios seen at least once
	COV_TIMEOUT:  cover property (fail_mode != FAIL_KEEP ##1 $rose(bus_fail_active));
	COV_CLEAR:    cover property (wr_clear && status_word[2]);
	COV_OVERRIDE: cover property ($rose(local_override));
	COV_READ_ST:  cover property (req.rd && req.addr == REG_STATUS ##1 rvalid);
	COV_CONTACT:  cover property (req.rd && req.addr == REG_SENSOR_VAL && sensor_kind == SENS_CONTACT);

endmodule

// *** tb/tb.sv ***
// tb: self-checking bench of the actuator register bank
// assumes vavr_regs and vavr_master are compiled first
`timescale 1ns/100ps
module tb;
	import vavr_pkg::*;

	// --------
	// signals
	// --------
	logic        clock;       // 100 MHz clock
	logic        rst_b;       // sync reset, active low
	vavr_req_t   req;         // access from master model
	logic [15:0] rdata;       // read data
	logic        rvalid;      // read data marker
	vavr_plant_t plant;       // plant levels and events
	logic [15:0] min_limit;   // limit outputs
	logic [15:0] max_limit;
	vavr_sens_t  sensor_kind; // settings
	vavr_fail_t  fail_mode;
	logic        bus_fail_active;
	logic        local_override;
	logic [15:0] status_word;
	int          miscompares; // mismatches seen
	int          checks;      // comparisons made
	logic [15:0] got;         // last read word

	// --------
	// instances
	// --------
	vavr_regs #(.TICK_CYC(4), .WD_TICKS(3)) i_vavr_regs (
		.clock(clock), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid),
		.plant(plant), .min_limit(min_limit), .max_limit(max_limit),
		.sensor_kind(sensor_kind), .fail_mode(fail_mode),
		.bus_fail_active(bus_fail_active), .local_override(local_override),
		.status_word(status_word));
	vavr_master i_vavr_master (
		.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));

	// clock, 10 ns period
	initial clock = 1'b0;
	always #5 clock = ~clock;

	// --------
	// helpers
	// --------
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// read a register and compare
	task automatic rchk(input string n, input logic [15:0] a, input logic [15:0] e);
		i_vavr_master.rd(a, got);
		chk(n, e, got);
	endtask

	// write, then read back
	task automatic wchk(input string n, input logic [15:0] a, input logic [15:0] d,
			input logic [15:0] e);
		i_vavr_master.wr(a, d);
		rchk(n, a, e);
	endtask

	// counts and verdict
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard, far beyond the expected run
	initial begin
		#50000;
		miscompares++;
		$display("ERROR watchdog expected finish seen timeout");
		print_verdict();
	end

	// --------
	// tests
	// --------
	initial begin
		miscompares = 0;
		checks = 0;
		plant = '0;
		rst_b = 1'b0;
		repeat (5) @(posedge clock);
		#1;
		rst_b = 1'b1;
		// reset values and map holes
		rchk("min", REG_MIN_LIMIT, 16'h0000);
		rchk("max", REG_MAX_LIMIT, 16'h2710);
		rchk("kind", REG_SENS_KIND, 16'h0000);
		rchk("fail", REG_FAIL_POS, 16'h0000);
		rchk("status", REG_STATUS, 16'h0000);
		wchk("rsvd", REG_RESERVED, 16'h5a5a, 16'h0000);
		$display("test reset_map done");
		// flow values only for type 2
		plant.abs_flow = 16'h0123;
		plant.nom_flow = 16'h0456;
		for (int t = 0; t < 4; t++) begin
			plant.act_type = t[15:0];
			rchk("abs", REG_ABS_FLOW, (t == 2) ? 16'h0123 : 16'hffff);
			rchk("nom", REG_NOM_FLOW, (t == 2) ? 16'h0456 : 16'hffff);
		end
		$display("test flow done");
		// limit boundaries
		wchk("min", REG_MIN_LIMIT, 16'h2710, 16'h2710);
		wchk("min", REG_MIN_LIMIT, 16'h2711, 16'h2710);
		wchk("max", REG_MAX_LIMIT, 16'h07cf, 16'h2710);
		wchk("max", REG_MAX_LIMIT, 16'h07d0, 16'h07d0);
		wchk("max", REG_MAX_LIMIT, 16'h2711, 16'h07d0);
		chk("max_out", 16'h07d0, max_limit);
		chk("min_out", 16'h2710, min_limit);
		$display("test limits done");
		// sensor kinds and local override
		plant.sensor_mv = 16'h1234;
		plant.contact = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk("ovr", 16'h0001, {15'h0000, local_override});
		wchk("kind", REG_SENS_KIND, 16'h0002, 16'h0000);
		wchk("kind", REG_SENS_KIND, 16'h0001, 16'h0001);
		repeat (2) @(posedge clock); // two quiet cycles; the new kind already applies
		rchk("sens", REG_SENSOR_VAL, 16'h1234);
		chk("ovr", 16'h0000, {15'h0000, local_override});
		wchk("kind", REG_SENS_KIND, 16'h0004, 16'h0004);
		rchk("sens", REG_SENSOR_VAL, 16'h0001);
		chk("kind_out", 16'h0004, {13'h0000, sensor_kind});
		wchk("kind", REG_SENS_KIND, 16'h0003, 16'h0004);
		wchk("kind", REG_SENS_KIND, 16'h0000, 16'h0000);
		rchk("sens", REG_SENSOR_VAL, 16'h0000);
		$display("test sensor done");
		// fault and service flags, clear command
		plant.malf_evt = 8'hff;
		plant.activity = 1'b1;
		plant.gear_off = 1'b1;
		@(posedge clock);
		#1;
		plant.malf_evt = 8'h00;
		rchk("status", REG_STATUS, 16'h03f7);
		plant.activity = 1'b0;
		plant.gear_off = 1'b0;
		i_vavr_master.wr(REG_COMMAND, CMD_CLEAR_FAULTS);
		rchk("status", REG_STATUS, 16'h0011);
		chk("word", 16'h0011, status_word);
		// clear again with a fault event on bit 1 in the same cycle
		fork
			i_vavr_master.wr(REG_COMMAND, CMD_CLEAR_FAULTS);
			begin
				@(posedge clock);
				#1;
				plant.malf_evt = 8'h02;
				@(posedge clock);
				#1;
				plant.malf_evt = 8'h00;
			end
		join
		rchk("status", REG_STATUS, 16'h0013);
		$display("test status done");
		// supervision timeout, 12 cycles here
		chk("bfa", 16'h0000, {15'h0000, bus_fail_active});
		for (int m = 1; m < 4; m++) begin
			wchk("fail", REG_FAIL_POS, m[15:0], m[15:0]);
		end
		wchk("fail", REG_FAIL_POS, 16'h0004, 16'h0003);
		chk("fail_out", 16'h0003, {14'h0000, fail_mode});
		i_vavr_master.wr(REG_SETPOINT, 16'h1000);
		repeat (8) @(posedge clock);
		#1;
		chk("bfa", 16'h0000, {15'h0000, bus_fail_active});
		i_vavr_master.wr(REG_SETPOINT, 16'h1000);
		repeat (11) @(posedge clock);
		#1;
		chk("bfa", 16'h0000, {15'h0000, bus_fail_active});
		@(posedge clock);
		#1;
		chk("bfa", 16'h0001, {15'h0000, bus_fail_active});
		rchk("status", REG_STATUS, 16'h0413);
		i_vavr_master.wr(REG_OVERRIDE, 16'h0000);
		@(posedge clock);
		#1;
		chk("bfa", 16'h0000, {15'h0000, bus_fail_active});
		i_vavr_master.wr(REG_FAIL_POS, 16'h0000);
		repeat (30) @(posedge clock);
		#1;
		chk("bfa", 16'h0000, {15'h0000, bus_fail_active});
		$display("test watchdog done");
		print_verdict();
	end
endmodule

// *** tb/vavr_master.sv ***
// vavr_master: bus controller model issuing register accesses
// assumes the bank samples req on rising clock edges
`timescale 1ns/100ps
module vavr_master (
	// clock
	input  wire logic           clock,
	// register access
	output vavr_pkg::vavr_req_t req,
	input  wire logic [15:0]    rdata,
	input  wire logic           rvalid
);
	import vavr_pkg::*;

	// --------
	// access tasks
	// --------
	// bus idle at time zero
	initial req = '0;

	// one write strobe, released bus shows inverted values
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		#1;
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		#1;
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// one read strobe; data only counts with rvalid
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clock);
		#1;
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clock);
		#1;
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
		d = (rvalid === 1'b1) ? rdata : 'x;
	endtask
endmodule
